//--- core/usb_host_pipe_manager.sv
// USB host pipe manager: bus state, one pipe, its banks and registers
`timescale 1ns/1ns
// What this block does
// - Accepted config: only token and, for interrupt pipes, poll interval change
// - Control pipe with two banks is refused
// - Pipe disable resets every pipe register except the latched token fields (type, address, length, toggle, bank, iso)
// - Reset request drives bus reset, then flags it
// - Sent bus reset clears pipe config and allocation
// - Reset from suspend: wake flag, frames re-enabled
// - Sent bus reset clears target device address
// - Clearing frame enable suspends, stops frame markers
// - Suspend: non-idle sets wake, K sets upstream
// - Finished downstream resume re-enables frame markers
// - Pipe reset clears banks, flags and token request only
// - Control pipe toggle initialised from token
// - Pending OUT bank overrides suspend until sent
// - OUT manual: free bank flags, release advances
// - OUT autoswitch: full bank releases itself
// - IN policy: count plus one, or endless
// - IN requests start when halt is cleared
// - IN manual: full bank flags, release advances
// - IN autoswitch: emptied bank releases itself
// - Isochronous CRC error flags, bank still full
// - Only hardware clears the bus reset request
// - Only hardware clears the resume request
module usb_host_pipe_manager
   import usb_host_pkg::*;
#(
   parameter int unsigned RESET_CYC = BUS_RESET_CYC,
   parameter int unsigned RSM_CYC = RESUME_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic irq_o,
   output logic bus_reset_o,
   output logic resume_o,
   output logic sof_en_o,
   input wire logic bus_nonidle_i,
   input wire logic bus_kstate_i,
   output logic tok_req_o,
   output logic [1:0] tok_type_o,
   output logic [6:0] tok_addr_o,
   output logic tok_toggle_o,
   output logic tok_bank_o,
   output logic tok_iso_o,
   output logic [6:0] tok_len_o,
   input wire logic xfer_done_i,
   input wire logic xfer_ok_i,
   input wire logic crc_err_i,
   input wire logic stall_i,
   input wire logic link_we_i,
   input wire logic [5:0] link_addr_i,
   input wire logic [7:0] link_wdata_i,
   output logic [7:0] link_rdata_o
);
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a[7:2] == off[7:2]);
   endfunction

   wbst_t wst_r, wst_nxt;
   logic [31:0] dat_r, dat_nxt, rd_mux;
   logic req, wr, rd;
   logic w_hctrl, w_hflag, w_hien, w_daddr, w_pen, w_prst;
   logic w_pcfg, w_pctl, w_pstat, w_pien, w_fifo, r_fifo;

   hstate_t hst_r, hst_nxt;
   logic frame_marker_enable_r, frame_marker_enable_nxt, brst_r, brst_nxt, rsm_r, rsm_nxt;
   logic [3:0] hflag_r, hflag_nxt, hien_r, hien_nxt, hset, hclr;
   logic [6:0] daddr_r, daddr_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic reset_done, out_pend, suspended;

   logic pen_r, pen_nxt, act_r, act_nxt, banks_r, banks_nxt, auto_r, auto_nxt;
   logic [1:0] ptype_r, ptype_nxt, tok_r, tok_nxt, size_r, size_nxt;
   logic [7:0] poll_r, poll_nxt, rqcnt_r, rqcnt_nxt;
   logic halt_r, halt_nxt, pol_r, pol_nxt, tog_r, tog_nxt;
   logic [8:0] left_r, left_nxt;
   logic [2:0] pflag_r, pflag_nxt, pien_r, pien_nxt, pset, pclr;
   logic [1:0] filled_r, filled_nxt;
   logic [1:0][6:0] bcnt_r, bcnt_nxt;
   logic [6:0] cpos_r, cpos_nxt, size_bytes;
   logic cbank_r, cbank_nxt, ubank_r, ubank_nxt;
   logic busy_r, busy_nxt, hand_d_r, moved_r, moved_nxt;
   logic [1:0] ttype_r, ttype_nxt;
   logic [6:0] taddr_r, taddr_nxt, tlen_r, tlen_nxt;
   logic ttog_r, ttog_nxt, tbank_r, tbank_nxt, tiso_r, tiso_nxt;
   logic cfg_ok, is_in, hand, kill, prst, fw, fr, rel, issue, good;
   logic [7:0] a_rdata;

   // Bus slave: two wait cycles so FIFO reads come out of the RAM register
   assign req = cyc_i & stb_i;
   assign ack_o = req & (wst_r == W_ACK);
   assign wr = ack_o & we_i;
   assign rd = ack_o & ~we_i;
   assign dat_o = dat_r;
   assign w_hctrl = wr & sel_i[0] & hit(adr_i, A_HCTRL);
   assign w_hflag = wr & sel_i[0] & hit(adr_i, A_HFLAG);
   assign w_hien = wr & sel_i[0] & hit(adr_i, A_HIEN);
   assign w_daddr = wr & sel_i[0] & hit(adr_i, A_DADDR);
   assign w_pen = wr & sel_i[0] & hit(adr_i, A_PEN);
   assign w_prst = wr & sel_i[0] & hit(adr_i, A_PRST);
   assign w_pcfg = wr & (&sel_i[2:0]) & hit(adr_i, A_PCFG);
   assign w_pctl = wr & (&sel_i[1:0]) & hit(adr_i, A_PCTL);
   assign w_pstat = wr & sel_i[0] & hit(adr_i, A_PSTAT);
   assign w_pien = wr & sel_i[0] & hit(adr_i, A_PIEN);
   assign w_fifo = wr & sel_i[0] & hit(adr_i, A_FIFO);
   assign r_fifo = rd & hit(adr_i, A_FIFO);

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit(adr_i, A_HCTRL)) rd_mux = {29'h0, rsm_r, brst_r, frame_marker_enable_r};
      else if (hit(adr_i, A_HFLAG)) rd_mux = {28'h0, hflag_r};
      else if (hit(adr_i, A_HIEN)) rd_mux = {28'h0, hien_r};
      else if (hit(adr_i, A_DADDR)) rd_mux = {25'h0, daddr_r};
      else if (hit(adr_i, A_PEN)) rd_mux = {31'h0, pen_r};
      else if (hit(adr_i, A_PCFG))
         rd_mux = {8'h0, poll_r, 7'h0, act_r, auto_r, banks_r, size_r, tok_r, ptype_r};
      else if (hit(adr_i, A_PCTL)) rd_mux = {16'h0, rqcnt_r, 5'h0, pol_r, hand, halt_r};
      else if (hit(adr_i, A_PSTAT))
         rd_mux = {17'h0, bcnt_r[cbank_r], 3'h0, tog_r, cfg_ok, pflag_r};
      else if (hit(adr_i, A_PIEN)) rd_mux = {29'h0, pien_r};
      else if (hit(adr_i, A_FIFO)) rd_mux = {24'h0, a_rdata};
   end

   always_comb begin
      wst_nxt = W_IDLE;
      dat_nxt = dat_r;
      case (wst_r)
         W_IDLE: begin
            if (req) wst_nxt = W_WAIT;
         end
         W_WAIT: begin
            if (req) wst_nxt = W_ACK;
            dat_nxt = rd_mux;
         end
         W_ACK: wst_nxt = W_IDLE;
         default: wst_nxt = W_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wst_r <= W_IDLE;
         dat_r <= 32'h0000_0000;
      end else begin
         wst_r <= wst_nxt;
         dat_r <= dat_nxt;
      end
   end

   // Host bus state: running, driving reset, driving resume
   assign suspended = (hst_r == H_RUN) & ~frame_marker_enable_r & ~out_pend;
   assign bus_reset_o = (hst_r == H_RESET);
   assign resume_o = (hst_r == H_RESUME);
   assign sof_en_o = (hst_r == H_RUN) & ~suspended;
   assign irq_o = (|(hflag_r & hien_r)) | (|(pflag_r & pien_r));

   always_comb begin
      hst_nxt = hst_r;
      frame_marker_enable_nxt = frame_marker_enable_r;
      brst_nxt = brst_r;
      rsm_nxt = rsm_r;
      hien_nxt = hien_r;
      daddr_nxt = daddr_r;
      cnt_nxt = cnt_r;
      hset = 4'h0;
      hclr = 4'h0;
      reset_done = 1'b0;
      if (w_hctrl) begin
         frame_marker_enable_nxt = dat_i[B_FRAME_MARKER_ENABLE];
         brst_nxt = brst_r | dat_i[B_BRST];
         rsm_nxt = rsm_r | dat_i[B_RSM];
      end
      if (w_hflag) hclr = dat_i[3:0];
      if (w_hien) hien_nxt = dat_i[3:0];
      if (w_daddr) daddr_nxt = dat_i[6:0];
      case (hst_r)
         H_RUN: begin
            cnt_nxt = '0;
            if (brst_r) begin
               hst_nxt = H_RESET;
            end else if (rsm_r) begin
               hst_nxt = H_RESUME;
            end else if (suspended) begin
               hset[F_WAKE] = bus_nonidle_i | bus_kstate_i;
               hset[F_URSM] = bus_kstate_i;
            end
         end
         H_RESET: begin
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r == CNT_W'(RESET_CYC - 1)) begin
               reset_done = 1'b1;
               hst_nxt = H_RUN;
               brst_nxt = 1'b0;
               hset[F_RST] = 1'b1;
               daddr_nxt = DADDR_RST;
               if (!frame_marker_enable_r) begin
                  hset[F_WAKE] = 1'b1;
                  frame_marker_enable_nxt = 1'b1;
               end
            end
         end
         H_RESUME: begin
            // Length fixed here; firmware must request it within 1 ms
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r == CNT_W'(RSM_CYC - 1)) begin
               hst_nxt = H_RUN;
               rsm_nxt = 1'b0;
               frame_marker_enable_nxt = 1'b1;
               hset[F_RSMD] = 1'b1;
            end
         end
         default: hst_nxt = H_RUN;
      endcase
      // Hardware set wins over a clear in the same cycle
      hflag_nxt = (hflag_r & ~hclr) | hset;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hst_r <= H_RUN;
         frame_marker_enable_r <= 1'b0;
         brst_r <= 1'b0;
         rsm_r <= 1'b0;
         hflag_r <= 4'h0;
         hien_r <= 4'h0;
         daddr_r <= DADDR_RST;
         cnt_r <= '0;
      end else begin
         hst_r <= hst_nxt;
         frame_marker_enable_r <= frame_marker_enable_nxt;
         brst_r <= brst_nxt;
         rsm_r <= rsm_nxt;
         hflag_r <= hflag_nxt;
         hien_r <= hien_nxt;
         daddr_r <= daddr_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Pipe: configuration, bank ownership, token issue
   assign cfg_ok = act_r & ~((ptype_r == T_CTRL) & banks_r);
   assign is_in = (tok_r == TK_IN);
   // Handoff bit is the CPU owning the current bank
   assign hand = is_in ? filled_r[cbank_r] : ~filled_r[cbank_r];
   // Largest code gives 64 bytes; code 0 gives 8, the default control pipe size
   assign size_bytes = SIZE_BASE << size_r;
   assign out_pend = pen_r & cfg_ok & ~is_in & ~halt_r & filled_r[ubank_r];
   assign issue = pen_r & cfg_ok & ~halt_r & ~busy_r & (hst_r == H_RUN) &
                  (is_in ? (~filled_r[ubank_r] & frame_marker_enable_r) : filled_r[ubank_r]);
   assign fw = w_fifo & ~is_in & hand & (cpos_r != size_bytes);
   assign fr = r_fifo & is_in & hand & (cpos_r != bcnt_r[cbank_r]);
   assign kill = (w_pen & ~dat_i[0] & pen_r) | reset_done;
   assign prst = w_prst;
   assign good = xfer_ok_i | (tiso_r & crc_err_i & (ttype_r == TK_IN));

   always_comb begin
      pen_nxt = pen_r;
      act_nxt = act_r;
      banks_nxt = banks_r;
      auto_nxt = auto_r;
      ptype_nxt = ptype_r;
      tok_nxt = tok_r;
      size_nxt = size_r;
      poll_nxt = poll_r;
      rqcnt_nxt = rqcnt_r;
      halt_nxt = halt_r;
      pol_nxt = pol_r;
      tog_nxt = tog_r;
      left_nxt = left_r;
      pien_nxt = pien_r;
      filled_nxt = filled_r;
      bcnt_nxt = bcnt_r;
      cpos_nxt = cpos_r;
      cbank_nxt = cbank_r;
      ubank_nxt = ubank_r;
      busy_nxt = busy_r;
      ttype_nxt = ttype_r;
      taddr_nxt = taddr_r;
      tlen_nxt = tlen_r;
      ttog_nxt = ttog_r;
      tbank_nxt = tbank_r;
      tiso_nxt = tiso_r;
      pset = 3'h0;
      pclr = 3'h0;
      rel = 1'b0;
      moved_nxt = 1'b0;
      if (w_pen) pen_nxt = dat_i[0];
      if (w_pcfg) begin
         tok_nxt = dat_i[C_TOK +: 2];
         if (!cfg_ok) begin
            ptype_nxt = dat_i[C_TYPE +: 2];
            size_nxt = dat_i[C_SIZE +: 2];
            banks_nxt = dat_i[C_BANKS];
            auto_nxt = dat_i[C_AUTO];
            act_nxt = dat_i[C_ACT];
         end
         if (!cfg_ok || ptype_r == T_INT) poll_nxt = dat_i[C_POLL +: 8];
         if (ptype_nxt == T_CTRL) tog_nxt = (tok_nxt != TK_SETUP);
      end
      if (w_pctl) begin
         rqcnt_nxt = dat_i[K_CNT +: 8];
         pol_nxt = dat_i[K_POL];
         halt_nxt = dat_i[K_HALT];
         if (halt_r && !dat_i[K_HALT]) left_nxt = {1'b0, rqcnt_nxt} + 9'h001;
         rel = hand & ~dat_i[K_HAND];
      end
      if (w_pstat) pclr = dat_i[2:0];
      if (w_pien) pien_nxt = dat_i[2:0];
      if (fw) begin
         cpos_nxt = cpos_r + 1'b1;
         bcnt_nxt[cbank_r] = cpos_r + 1'b1;
         if (auto_r && cpos_r + 7'h01 == size_bytes) rel = 1'b1;
      end
      if (fr) begin
         cpos_nxt = cpos_r + 1'b1;
         if (auto_r && cpos_r + 7'h01 == bcnt_r[cbank_r]) rel = 1'b1;
      end
      if (rel) begin
         filled_nxt[cbank_r] = ~is_in;
         if (is_in) bcnt_nxt[cbank_r] = 7'h00;
         cpos_nxt = 7'h00;
         cbank_nxt = banks_r ? ~cbank_r : cbank_r;
         moved_nxt = 1'b1;
      end
      if (issue) begin
         busy_nxt = 1'b1;
         ttype_nxt = tok_r;
         taddr_nxt = daddr_r;
         ttog_nxt = tog_r;
         tbank_nxt = ubank_r;
         tiso_nxt = (ptype_r == T_ISO);
         tlen_nxt = bcnt_r[ubank_r];
         if (is_in) begin
            bcnt_nxt[ubank_r] = 7'h00;
            if (!pol_r) begin
               left_nxt = left_r - 9'h001;
               if (left_r <= 9'h001) halt_nxt = 1'b1;
            end
         end
      end
      if (busy_r && link_we_i && ttype_r == TK_IN && {1'b0, link_addr_i} >= bcnt_r[tbank_r])
         bcnt_nxt[tbank_r] = {1'b0, link_addr_i} + 7'h01;
      if (busy_r && xfer_done_i) begin
         busy_nxt = 1'b0;
         if (stall_i) pset[P_ERR] = 1'b1;
         if (tiso_r && crc_err_i && ttype_r == TK_IN) pset[P_ERR] = 1'b1;
         if (good) begin
            filled_nxt[tbank_r] = (ttype_r == TK_IN);
            ubank_nxt = banks_r ? ~tbank_r : tbank_r;
            tog_nxt = ~ttog_r;
         end
      end
      // Flag raised on each bank handed to the CPU, also back to back
      pset[P_OFREE] = ~is_in & hand & (~hand_d_r | moved_r);
      pset[P_IFULL] = is_in & hand & (~hand_d_r | moved_r);
      pflag_nxt = (pflag_r & ~pclr) | pset;
      if (prst) begin
         // Keeps configuration and toggle
         filled_nxt = 2'b00;
         bcnt_nxt = '0;
         cpos_nxt = 7'h00;
         cbank_nxt = 1'b0;
         ubank_nxt = 1'b0;
         busy_nxt = 1'b0;
         moved_nxt = 1'b0;
         pflag_nxt = 3'h0;
      end
      if (kill) begin
         pen_nxt = 1'b0;
         act_nxt = 1'b0;
         banks_nxt = 1'b0;
         auto_nxt = 1'b0;
         ptype_nxt = T_CTRL;
         tok_nxt = TK_SETUP;
         size_nxt = 2'h0;
         poll_nxt = 8'h00;
         rqcnt_nxt = 8'h00;
         halt_nxt = HALT_RST;
         pol_nxt = 1'b0;
         tog_nxt = 1'b0;
         left_nxt = 9'h000;
         pien_nxt = 3'h0;
         filled_nxt = 2'b00;
         bcnt_nxt = '0;
         cpos_nxt = 7'h00;
         cbank_nxt = 1'b0;
         ubank_nxt = 1'b0;
         busy_nxt = 1'b0;
         moved_nxt = 1'b0;
         pflag_nxt = 3'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pen_r <= 1'b0;
         act_r <= 1'b0;
         banks_r <= 1'b0;
         auto_r <= 1'b0;
         ptype_r <= T_CTRL;
         tok_r <= TK_SETUP;
         size_r <= 2'h0;
         poll_r <= 8'h00;
         rqcnt_r <= 8'h00;
         halt_r <= HALT_RST;
         pol_r <= 1'b0;
         tog_r <= 1'b0;
         left_r <= 9'h000;
         pflag_r <= 3'h0;
         pien_r <= 3'h0;
         filled_r <= 2'b00;
         bcnt_r <= '0;
         cpos_r <= 7'h00;
         cbank_r <= 1'b0;
         ubank_r <= 1'b0;
         busy_r <= 1'b0;
         hand_d_r <= 1'b0;
         moved_r <= 1'b0;
         ttype_r <= TK_SETUP;
         taddr_r <= DADDR_RST;
         tlen_r <= 7'h00;
         ttog_r <= 1'b0;
         tbank_r <= 1'b0;
         tiso_r <= 1'b0;
      end else begin
         pen_r <= pen_nxt;
         act_r <= act_nxt;
         banks_r <= banks_nxt;
         auto_r <= auto_nxt;
         ptype_r <= ptype_nxt;
         tok_r <= tok_nxt;
         size_r <= size_nxt;
         poll_r <= poll_nxt;
         rqcnt_r <= rqcnt_nxt;
         halt_r <= halt_nxt;
         pol_r <= pol_nxt;
         tog_r <= tog_nxt;
         left_r <= left_nxt;
         pflag_r <= pflag_nxt;
         pien_r <= pien_nxt;
         filled_r <= filled_nxt;
         bcnt_r <= bcnt_nxt;
         cpos_r <= cpos_nxt;
         cbank_r <= cbank_nxt;
         ubank_r <= ubank_nxt;
         busy_r <= busy_nxt;
         hand_d_r <= hand;
         moved_r <= moved_nxt;
         ttype_r <= ttype_nxt;
         taddr_r <= taddr_nxt;
         tlen_r <= tlen_nxt;
         ttog_r <= ttog_nxt;
         tbank_r <= tbank_nxt;
         tiso_r <= tiso_nxt;
      end
   end

   assign tok_req_o = busy_r;
   assign tok_type_o = ttype_r;
   assign tok_addr_o = taddr_r;
   assign tok_toggle_o = ttog_r;
   assign tok_bank_o = tbank_r;
   assign tok_iso_o = tiso_r;
   assign tok_len_o = tlen_r;

   bank_ram u_ram (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .a_we_i(fw),
      .a_addr_i({cbank_r, cpos_r[5:0]}),
      .a_wdata_i(dat_i[7:0]),
      .a_rdata_o(a_rdata),
      .b_we_i(busy_r & link_we_i & (ttype_r == TK_IN)),
      .b_addr_i({tbank_r, link_addr_i}),
      .b_wdata_i(link_wdata_i),
      .b_rdata_o(link_rdata_o)
   );
endmodule

//--- pkg/usb_host_pkg.sv
// Shared constants and types for the USB host pipe manager
package usb_host_pkg;
   // Clock rate and bus signalling durations
   localparam int unsigned CLK_KHZ = 125000;
   localparam int unsigned BUS_RESET_MS = 10;
   localparam int unsigned RESUME_MS = 20;
   localparam int unsigned BUS_RESET_CYC = BUS_RESET_MS * CLK_KHZ;
   localparam int unsigned RESUME_CYC = RESUME_MS * CLK_KHZ;
   localparam int CNT_W = 24;
   // Register byte offsets
   localparam logic [7:0] A_HCTRL = 8'h00;
   localparam logic [7:0] A_HFLAG = 8'h04;
   localparam logic [7:0] A_HIEN = 8'h08;
   localparam logic [7:0] A_DADDR = 8'h0c;
   localparam logic [7:0] A_PEN = 8'h10;
   localparam logic [7:0] A_PRST = 8'h14;
   localparam logic [7:0] A_PCFG = 8'h18;
   localparam logic [7:0] A_PCTL = 8'h1c;
   localparam logic [7:0] A_PSTAT = 8'h20;
   localparam logic [7:0] A_PIEN = 8'h24;
   localparam logic [7:0] A_FIFO = 8'h28;
   // Host control bits
   localparam int B_FRAME_MARKER_ENABLE = 0;
   localparam int B_BRST = 1;
   localparam int B_RSM = 2;
   // Host flag bits, same positions in the enable register
   localparam int F_RST = 0;
   localparam int F_WAKE = 1;
   localparam int F_URSM = 2;
   localparam int F_RSMD = 3;
   // Pipe configuration fields
   localparam int C_TYPE = 0;
   localparam int C_TOK = 2;
   localparam int C_SIZE = 4;
   localparam int C_BANKS = 6;
   localparam int C_AUTO = 7;
   localparam int C_ACT = 8;
   localparam int C_POLL = 16;
   // Pipe control fields
   localparam int K_HALT = 0;
   localparam int K_HAND = 1;
   localparam int K_POL = 2;
   localparam int K_CNT = 8;
   // Pipe flag bits
   localparam int P_OFREE = 0;
   localparam int P_IFULL = 1;
   localparam int P_ERR = 2;
   // Pipe types and tokens
   localparam logic [1:0] T_CTRL = 2'h0;
   localparam logic [1:0] T_ISO = 2'h1;
   localparam logic [1:0] T_BULK = 2'h2;
   localparam logic [1:0] T_INT = 2'h3;
   localparam logic [1:0] TK_SETUP = 2'h0;
   localparam logic [1:0] TK_IN = 2'h1;
   localparam logic [1:0] TK_OUT = 2'h2;
   // Reset values
   localparam logic [6:0] DADDR_RST = 7'h00;
   localparam logic HALT_RST = 1'b1;
   localparam logic [6:0] SIZE_BASE = 7'h08;
   typedef enum logic [2:0] {
      H_RUN = 3'b001,
      H_RESET = 3'b010,
      H_RESUME = 3'b100
   } hstate_t;
   typedef enum logic [2:0] {
      W_IDLE = 3'b001,
      W_WAIT = 3'b010,
      W_ACK = 3'b100
   } wbst_t;
endpackage

//--- core/bank_ram.sv
// Two-bank pipe data memory with registered read ports
`timescale 1ns/1ns
module bank_ram (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic a_we_i,
   input wire logic [6:0] a_addr_i,
   input wire logic [7:0] a_wdata_i,
   output logic [7:0] a_rdata_o,
   input wire logic b_we_i,
   input wire logic [6:0] b_addr_i,
   input wire logic [7:0] b_wdata_i,
   output logic [7:0] b_rdata_o
);
   logic [7:0] mem [128];

   // Ports never write the same bank at once: ownership is exclusive
   always_ff @(posedge clk_i) begin
      if (a_we_i) begin
         mem[a_addr_i] <= a_wdata_i;
      end
      if (b_we_i) begin
         mem[b_addr_i] <= b_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         a_rdata_o <= 8'h00;
         b_rdata_o <= 8'h00;
      end else begin
         a_rdata_o <= mem[a_addr_i];
         b_rdata_o <= mem[b_addr_i];
      end
   end
endmodule

//--- testbench/usb_host_pipe_manager_asserts.sv
// Port checker for the USB host pipe manager
`timescale 1ns/1ns
module usb_host_pipe_manager_asserts #(
   parameter int unsigned RESET_CYC = 20,
   parameter int unsigned RSM_CYC = 30
) (
   input wire logic clk_i, rst_i, stb_i, ack_o, bus_reset_o,
   input wire logic resume_o, sof_en_o, tok_req_o, xfer_done_i
);
   logic [23:0] rc_r, mc_r;
   // Length of the current reset and resume pulses
   always_ff @(posedge clk_i) begin
      rc_r <= (rst_i || !bus_reset_o) ? 24'h0 : rc_r + 24'h1;
      mc_r <= (rst_i || !resume_o) ? 24'h0 : mc_r + 24'h1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence rst_end; $fell(bus_reset_o); endsequence
   sequence rsm_end; $fell(resume_o); endsequence
   ack_lat_a: assert property ($rose(stb_i) |-> ##2 ack_o) else $error("ack late");
   ack_one_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
   rst_len_a: assert property (rst_end |-> rc_r == RESET_CYC)
      else $error("bus reset length");
   rsm_len_a: assert property (rsm_end |-> mc_r == RSM_CYC)
      else $error("resume length");
   rst_sof_a: assert property (rst_end |-> ##[0:2] sof_en_o)
      else $error("frames off after reset");
   rsm_sof_a: assert property (rsm_end |-> ##[0:2] sof_en_o)
      else $error("frames off after resume");
   rst_tok_a: assert property (rst_end |-> !tok_req_o) else $error("token at reset");
   tok_end_a: assert property (tok_req_o && xfer_done_i |=> !tok_req_o)
      else $error("token held");
endmodule
bind usb_host_pipe_manager usb_host_pipe_manager_asserts #(
   .RESET_CYC(RESET_CYC),
   .RSM_CYC(RSM_CYC)
) u_chk (.clk_i(clk_i), .rst_i(rst_i), .stb_i(stb_i), .ack_o(ack_o),
   .bus_reset_o(bus_reset_o), .resume_o(resume_o), .sof_en_o(sof_en_o),
   .tok_req_o(tok_req_o), .xfer_done_i(xfer_done_i));

//--- testbench/usb_peripheral_model.sv
// Behavioural USB peripheral answering host tokens
`timescale 1ns/1ns
module usb_peripheral_model
   import usb_host_pkg::*;
(
   input wire logic clk_i, rst_i, tok_req_i, crc_i, wake_i,
   input wire logic [1:0] tok_type_i,
   input wire logic [5:0] dly_i,
   output logic xfer_done_o, xfer_ok_o, crc_err_o, stall_o, link_we_o, nonidle_o, kstate_o,
   output logic [5:0] link_addr_o,
   output logic [7:0] link_wdata_o
);
   logic [5:0] cnt_r;
   always_ff @(posedge clk_i) cnt_r <= (rst_i || !tok_req_i) ? 6'h00 : cnt_r + 6'h01;
   // Four IN bytes, then completion after dly_i cycles
   assign link_we_o = tok_req_i && tok_type_i == TK_IN && cnt_r inside {[1:4]};
   // Released lines keep moving so no stale byte looks valid
   assign link_addr_o = link_we_o ? cnt_r - 6'h01 : ~cnt_r;
   assign link_wdata_o = link_we_o ? {2'h2, cnt_r} : {2'h1, ~cnt_r};
   assign xfer_done_o = tok_req_i && cnt_r == dly_i;
   assign xfer_ok_o = xfer_done_o;
   assign crc_err_o = xfer_done_o && crc_i;
   assign stall_o = 1'b0;
   assign nonidle_o = wake_i;
   assign kstate_o = wake_i;
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the USB host pipe manager
`timescale 1ns/1ns
module tb_top;
   import usb_host_pkg::*;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] m;} row_t;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, wake = 0, crc = 0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, dat_o, q;
   logic [5:0] dly = 6'h08, laddr;
   logic [7:0] lwd;
   logic [1:0] tok_type_o;
   logic ack_o, irq_o, bus_reset_o, resume_o, sof_en_o, tok_req_o;
   logic done, ok, cerr, stl, lwe, nidle, kst;
   logic [6:0] tadr, tlen, olen;
   int fail_count = 0, checks_done = 0, ntok = 0;
   row_t rows [16] = '{'{1'b1, A_HCTRL, 32'h1, 0},
      '{1'b0, A_PCTL, 32'h3, 32'hffff}, '{1'b0, 8'h3c, 32'h0, 32'hffffffff},
      '{1'b1, A_DADDR, 32'h15, 0}, '{1'b1, A_PEN, 32'h1, 0},
      '{1'b1, A_PCFG, 32'h130, 0}, '{1'b0, A_PSTAT, 32'h08, 32'h18},
      '{1'b1, A_PCFG, 32'h108, 0}, '{1'b0, A_PCFG, 32'h138, 32'h1ff},
      '{1'b0, A_PSTAT, 32'h18, 32'h18}, '{1'b1, A_PEN, 32'h0, 0},
      '{1'b0, A_PCFG, 32'h0, 32'hffffffff}, '{1'b1, A_PEN, 32'h1, 0},
      '{1'b1, A_PCFG, 32'h170, 0}, '{1'b0, A_PSTAT, 32'h0, 32'h8},
      '{1'b1, A_PEN, 32'h0, 0}};
   usb_host_pipe_manager #(.RESET_CYC(20), .RSM_CYC(30)) u_dut (.clk_i(clk_i),
      .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf),
      .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .bus_reset_o(bus_reset_o),
      .resume_o(resume_o), .sof_en_o(sof_en_o), .bus_nonidle_i(nidle), .bus_kstate_i(kst),
      .tok_req_o(tok_req_o), .tok_type_o(tok_type_o), .tok_addr_o(tadr), .tok_toggle_o(),
      .tok_bank_o(), .tok_iso_o(), .tok_len_o(tlen), .xfer_done_i(done), .xfer_ok_i(ok),
      .crc_err_i(cerr), .stall_i(stl), .link_we_i(lwe), .link_addr_i(laddr),
      .link_wdata_i(lwd), .link_rdata_o());
   usb_peripheral_model u_dev (.clk_i(clk_i), .rst_i(rst_i), .tok_req_i(tok_req_o),
      .crc_i(crc), .wake_i(wake), .tok_type_i(tok_type_o), .dly_i(dly),
      .xfer_done_o(done), .xfer_ok_o(ok), .crc_err_o(cerr), .stall_o(stl),
      .link_we_o(lwe), .nonidle_o(nidle), .kstate_o(kst), .link_addr_o(laddr),
      .link_wdata_o(lwd));
   initial forever #4 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (tok_req_o === 1'b1 && done === 1'b1) begin
         ntok++;
         olen = tlen;
         chk("tok_addr", {25'h0, tadr}, 32'h15);
      end
   end
   task end_sim;
      $display("checks %0d fails %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] g, e);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      int i;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      for (i = 0; i < 20 && ack_o !== 1'b1; i++) @(negedge clk_i);
      if (i == 20) begin fail_count++; end_sim; end
      @(posedge clk_i);
      r = dat_o;
      cyc <= 1'b0; stb <= 1'b0;
   endtask
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] m, e);
      logic [31:0] r;
      wb(1'b0, a, 32'h0, r);
      chk(n, r & m, e);
   endtask
   // Bounded wait on irq_o (s=1) or sof_en_o (s=0)
   task automatic wt(input logic s);
      int i;
      for (i = 0; i < 400 && (s ? irq_o : sof_en_o) !== 1'b1; i++) @(negedge clk_i);
      if (i == 400) begin fail_count++; end_sim; end
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) if (rows[i].w) wb(1'b1, rows[i].a, rows[i].d, q);
      else rdc("reg", rows[i].a, rows[i].m, rows[i].d);
      wb(1'b1, A_PEN, 32'h1, q);
      wb(1'b1, A_PCFG, 32'h105, q);
      wb(1'b1, A_PIEN, 32'h2, q);
      crc <= 1'b1;
      dly <= 6'h28;
      repeat (8) @(posedge clk_i);
      chk("tok_idle", {31'h0, tok_req_o}, 32'h0);
      wb(1'b1, A_PCTL, 32'h100, q);
      wt(1'b1);
      rdc("in_full", A_PSTAT, 32'h7f06, 32'h0406);
      crc <= 1'b0;
      dly <= 6'h06;
      wb(1'b1, A_PSTAT, 32'h6, q);
      wb(1'b1, A_PCTL, 32'h100, q);
      wt(1'b1);
      rdc("halted", A_PCTL, 32'h1, 32'h1);
      chk("in_count", 32'(ntok), 32'h2);
      wb(1'b1, A_PRST, 32'h0, q);
      rdc("pipe_rst", A_PSTAT, 32'h7f0f, 32'h8);
      rdc("cfg_kept", A_PCFG, 32'h1ff, 32'h105);
      wb(1'b1, A_PCFG, 32'h108, q);
      wb(1'b1, A_PSTAT, 32'h7, q);
      wb(1'b1, A_PIEN, 32'h1, q);
      wb(1'b1, A_FIFO, 32'h5a, q);
      wb(1'b1, A_PCTL, 32'h100, q);
      wt(1'b1);
      rdc("out_free", A_PSTAT, 32'h1, 32'h1);
      rdc("out_hand", A_PCTL, 32'h3, 32'h2);
      chk("out_len", {25'h0, olen}, 32'h1);
      wb(1'b1, A_PEN, 32'h0, q);
      wb(1'b1, A_HFLAG, 32'hf, q);
      wb(1'b1, A_HIEN, 32'h1, q);
      wb(1'b1, A_HCTRL, 32'h0, q);
      wb(1'b1, A_HCTRL, 32'h2, q);
      wb(1'b1, A_HCTRL, 32'h0, q);
      rdc("rst_hold", A_HCTRL, 32'h2, 32'h2);
      wt(1'b1);
      rdc("rst_flag", A_HFLAG, 32'hf, 32'h3);
      rdc("rst_ctl", A_HCTRL, 32'h7, 32'h1);
      rdc("addr_clr", A_DADDR, 32'h7f, 32'h0);
      rdc("ien_kept", A_HIEN, 32'hf, 32'h1);
      wb(1'b1, A_HFLAG, 32'hf, q);
      wb(1'b1, A_HCTRL, 32'h0, q);
      repeat (2) @(posedge clk_i);
      chk("suspend", {31'h0, sof_en_o}, 32'h0);
      wake <= 1'b1;
      repeat (4) @(posedge clk_i);
      wake <= 1'b0;
      rdc("wake", A_HFLAG, 32'hf, 32'h6);
      wb(1'b1, A_HCTRL, 32'h4, q);
      wt(1'b0);
      rdc("rsm_flag", A_HFLAG, 32'h8, 32'h8);
      rdc("rsm_ctl", A_HCTRL, 32'h7, 32'h1);
      end_sim;
   end
endmodule
